// >>> rtl/efa_params.svh
// Constants of the E1 alignment search block: offsets, fields, resets, framing.
// Assumes inclusion by bare name from the package and the design modules.
//
// What this block does
// - Config bit picks search algorithm one or two
// - Algorithm select bit resets to zero
// - Hunt stream for 7-bit alignment pattern first
// - Check non-alignment frame bit 2 is one
// - Pattern must reappear in third frame
// - Declare sync, optionally after two extra frames
// - Algorithm two holds off one frame on a bit 2 failure in the second frame
// - Extra frame check bit resets to zero
`ifndef EFA_PARAMS_SVH
`define EFA_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EFA_FRAMING_SELECT_OFS 8'h00
`define EFA_CTRL_OFS 8'h04
`define EFA_STATUS_OFS 8'h08
`define EFA_MASK_OFS 8'h0C
`define EFA_STATE_OFS 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EFA_ALIGN_ALGORITHM_SELECT_BIT 0
`define EFA_EXTRA_CHECK_BIT 1
`define EFA_CTRL_RESTART_BIT 0
`define EFA_EVT_GAINED_BIT 0
`define EFA_EVT_FAILED_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EFA_ALG_RST 1'h0
`define EFA_EXTRA_RST 1'h0
`define EFA_MASK_RST 2'h0

// ----------------------------------------------------------------
// Framing constants
// ----------------------------------------------------------------
`define EFA_FAS_PATTERN 7'h1B
`define EFA_SLOTS_PER_FRAME 32
`define EFA_BITS_PER_SLOT 8
`define EFA_FRAME_BITS (`EFA_SLOTS_PER_FRAME * `EFA_BITS_PER_SLOT)

`endif

// >>> rtl/efa_pkg.sv
// Types of the E1 alignment search block.
// Assumes efa_params.svh is reachable on the include path.
`include "efa_params.svh"

package efa_pkg;

	// Search steps
	typedef enum logic [2:0] {
		HUNT,       // Looking for the pattern
		CHK_NFAS,   // Next frame, bit 2 must be one
		CHK_FAS,    // Third frame, pattern again
		EXTRA_NFAS, // Extra check, non-alignment frame
		EXTRA_FAS,  // Extra check, alignment frame
		HOLD_OFF,   // One frame wait before hunting
		IN_SYNC     // Alignment declared
	} efa_state_e;

	// State of the main module, apart from the frame position counter
	typedef struct packed {
		efa_state_e state;  // Search step
		logic algSel;       // Search algorithm choice
		logic extraChk;     // Two extra frames before sync
		logic [7:0] shift;  // Last eight received bits
		logic [1:0] status; // Sticky events
		logic [1:0] mask;   // Interrupt enables
		logic wrPend;       // Write data phase pending
		logic [7:0] wrAddr; // Address of pending write
		logic [31:0] rdata; // Read data for data phase
		logic ready;        // Bus ready out
		logic irq;          // Interrupt out
		logic inSync;       // Alignment flag out
	} efa_state_s;

endpackage : efa_pkg

// >>> rtl/efa_frame_counter.sv
// Bit position counter within one E1 frame.
// Assumes step marks one received bit; clear puts the count at zero.
`timescale 1ns/100ps
`include "efa_params.svh"

module efa_frame_counter #(
	parameter int WIDTH = $clog2(`EFA_FRAME_BITS)
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic step,
	output logic [WIDTH-1:0] count
);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// Wraps naturally after one frame of bits
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (step) begin
			count <= WIDTH'(count + 1'b1);
		end
	end

endmodule : efa_frame_counter

// >>> rtl/efa_search.sv
// E1 frame alignment search engine with an AHB-Lite register slave.
// Assumes rxBit/rxBitEn are synchronous to ref_clk, bit 1 of each slot first,
// and that hready is this slave's own hreadyout.
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
`include "efa_params.svh"

module efa_search #(
	parameter int CNT_W = $clog2(`EFA_FRAME_BITS)
) (
	input wire logic ref_clk,
	input wire logic rst,
	// Line side
	input wire logic rxBit,
	input wire logic rxBitEn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Status outputs
	output logic irq,
	output logic fasInSync
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	efa_pkg::efa_state_s st_r;   // Registered state
	efa_pkg::efa_state_s st_nxt; // Next state
	logic [CNT_W-1:0] frmCnt;    // Bit position in frame
	logic [7:0] shiftNew;        // Shift register with current bit
	logic fasHit;                // Pattern in newest seven bits
	logic nfasOk;                // Bit 2 of newest slot is one
	logic frameEnd;              // Last bit of assumed slot 0
	logic cntClear;              // Restart frame position
	logic busTake;               // Address phase accepted
	logic restart;               // Software restart pulse
	logic rdClr;                 // Status read clears events
	logic gained;                // Event: sync declared
	logic failed;                // Event: search step failed
	logic [31:0] rdVal;          // Read mux value

	localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(`EFA_FRAME_BITS - 1);

	// ----------------------------------------------------------------
	// Line bit helpers
	// ----------------------------------------------------------------
	// Newest bit enters at the bottom; bit 2 of the slot sits at index 6
	assign shiftNew = {st_r.shift[6:0], rxBit};
	assign fasHit = (shiftNew[6:0] == `EFA_FAS_PATTERN);
	assign nfasOk = shiftNew[6];
	assign frameEnd = rxBitEn && (frmCnt == FRAME_LAST);
	assign cntClear = (st_r.state == efa_pkg::HUNT) && rxBitEn && fasHit;

	// Frame position counter
	efa_frame_counter #(
		.WIDTH(CNT_W)
	) efa_frame_counter_i (
		.ref_clk(ref_clk),
		.rst(rst),
		.clear(cntClear),
		.step(rxBitEn),
		.count(frmCnt)
	);

	// ----------------------------------------------------------------
	// Bus take and read mux
	// ----------------------------------------------------------------
	assign busTake = hsel && htrans[1] && hready;

	// Read value from registered state
	always_comb begin
		rdVal = 32'h0000_0000;
		unique case (haddr[7:0])
			`EFA_FRAMING_SELECT_OFS: begin
				rdVal[`EFA_ALIGN_ALGORITHM_SELECT_BIT] = st_r.algSel;
				rdVal[`EFA_EXTRA_CHECK_BIT] = st_r.extraChk;
			end
			`EFA_STATUS_OFS: begin
				rdVal[1:0] = st_r.status;
			end
			`EFA_MASK_OFS: begin
				rdVal[1:0] = st_r.mask;
			end
			`EFA_STATE_OFS: begin
				rdVal[0] = st_r.inSync;
				rdVal[6:4] = st_r.state;
			end
			default: begin
				rdVal = 32'h0000_0000; // Unmapped and write-only read zero
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		restart = 1'b0;
		gained = 1'b0;
		failed = 1'b0;
		rdClr = 1'b0;
		st_nxt.ready = 1'b1;

		// Write data phase
		if (st_r.wrPend) begin
			unique case (st_r.wrAddr)
				`EFA_FRAMING_SELECT_OFS: begin
					st_nxt.algSel = hwdata[`EFA_ALIGN_ALGORITHM_SELECT_BIT];
					st_nxt.extraChk = hwdata[`EFA_EXTRA_CHECK_BIT];
				end
				`EFA_CTRL_OFS: begin
					restart = hwdata[`EFA_CTRL_RESTART_BIT];
				end
				`EFA_MASK_OFS: begin
					st_nxt.mask = hwdata[1:0];
				end
				default: begin
					// Read-only or unmapped: ignored
				end
			endcase
		end

		// Address phase
		st_nxt.wrPend = 1'b0;
		if (busTake) begin
			st_nxt.wrPend = hwrite;
			st_nxt.wrAddr = haddr[7:0];
			if (!hwrite) begin
				st_nxt.rdata = rdVal;
				rdClr = (haddr[7:0] == `EFA_STATUS_OFS);
			end
		end

		// Shift in line bits
		if (rxBitEn) begin
			st_nxt.shift = shiftNew;
		end

		// Search machine
		if (restart) begin
			st_nxt.state = efa_pkg::HUNT;
		end else begin
			unique case (st_r.state)
				efa_pkg::HUNT: begin
					if (rxBitEn && fasHit) begin
						st_nxt.state = efa_pkg::CHK_NFAS;
					end
				end
				efa_pkg::CHK_NFAS: begin
					if (frameEnd) begin
						if (nfasOk) begin
							st_nxt.state = efa_pkg::CHK_FAS;
						end else begin
							failed = 1'b1;
							st_nxt.state = st_r.algSel ? efa_pkg::HOLD_OFF : efa_pkg::HUNT;
						end
					end
				end
				efa_pkg::CHK_FAS: begin
					if (frameEnd) begin
						if (!fasHit) begin
							failed = 1'b1;
							st_nxt.state = efa_pkg::HUNT;
						end else if (st_r.extraChk) begin
							st_nxt.state = efa_pkg::EXTRA_NFAS;
						end else begin
							gained = 1'b1;
							st_nxt.state = efa_pkg::IN_SYNC;
						end
					end
				end
				efa_pkg::EXTRA_NFAS: begin
					if (frameEnd) begin
						if (nfasOk) begin
							st_nxt.state = efa_pkg::EXTRA_FAS;
						end else begin
							failed = 1'b1;
							st_nxt.state = efa_pkg::HUNT;
						end
					end
				end
				efa_pkg::EXTRA_FAS: begin
					if (frameEnd) begin
						if (fasHit) begin
							gained = 1'b1;
							st_nxt.state = efa_pkg::IN_SYNC;
						end else begin
							failed = 1'b1;
							st_nxt.state = efa_pkg::HUNT;
						end
					end
				end
				efa_pkg::HOLD_OFF: begin
					if (frameEnd) begin
						st_nxt.state = efa_pkg::HUNT;
					end
				end
				efa_pkg::IN_SYNC: begin
					// Held until restart; loss criteria live elsewhere
				end
				default: begin
					st_nxt.state = efa_pkg::HUNT;
				end
			endcase
		end

		// Sticky events, set wins over read clear
		st_nxt.status = (rdClr ? 2'h0 : st_r.status);
		st_nxt.status[`EFA_EVT_GAINED_BIT] = st_nxt.status[`EFA_EVT_GAINED_BIT] | gained;
		st_nxt.status[`EFA_EVT_FAILED_BIT] = st_nxt.status[`EFA_EVT_FAILED_BIT] | failed;

		// Outputs from flops
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);
		st_nxt.inSync = (st_nxt.state == efa_pkg::IN_SYNC);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_r.state <= efa_pkg::HUNT;
			st_r.algSel <= `EFA_ALG_RST;
			st_r.extraChk <= `EFA_EXTRA_RST;
			st_r.shift <= 8'h00;
			st_r.status <= 2'h0;
			st_r.mask <= `EFA_MASK_RST;
			st_r.wrPend <= 1'b0;
			st_r.wrAddr <= 8'h00;
			st_r.rdata <= 32'h0000_0000;
			st_r.ready <= 1'b1;
			st_r.irq <= 1'b0;
			st_r.inSync <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hrdata = st_r.rdata;
	assign hreadyout = st_r.ready;
	assign hresp = 1'b0;
	assign irq = st_r.irq;
	assign fasInSync = st_r.inSync;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Write data phase aimed at the framing select register
	logic wrSelect;
	assign wrSelect = st_r.wrPend && (st_r.wrAddr == `EFA_FRAMING_SELECT_OFS);

	// Configuration bits
	a_alg_write: assert property (wrSelect |=>
		st_r.algSel == $past(hwdata[`EFA_ALIGN_ALGORITHM_SELECT_BIT]))
		else $error("alg select not written");
	a_alg_reset: assert property ($fell(rst) |-> !st_r.algSel)
		else $error("alg select not zero after reset");
	a_extra_reset: assert property ($fell(rst) |-> !st_r.extraChk)
		else $error("extra check not zero after reset");

	// Pattern hunt and the non-alignment frame check
	a_hunt_found: assert property (st_r.state == efa_pkg::HUNT && cntClear && !restart
		|=> st_r.state == efa_pkg::CHK_NFAS)
		else $error("pattern found but no step two");
	a_nfas_pass: assert property (st_r.state == efa_pkg::CHK_NFAS && frameEnd && nfasOk && !restart
		|=> st_r.state == efa_pkg::CHK_FAS)
		else $error("step two pass not to step three");
	a_nfas_fail: assert property (st_r.state == efa_pkg::CHK_NFAS && frameEnd && !nfasOk && !st_r.algSel
		&& !restart |=> st_r.state == efa_pkg::HUNT && st_r.status[`EFA_EVT_FAILED_BIT])
		else $error("step two failure not to hunt");

	// Third frame and the optional extra frames; in-sync flag moves with the state
	a_fas3_fail: assert property (st_r.state == efa_pkg::CHK_FAS && frameEnd && !fasHit && !restart
		|=> st_r.state == efa_pkg::HUNT)
		else $error("step three failure not to hunt");
	a_sync_now: assert property (st_r.state == efa_pkg::CHK_FAS && frameEnd && fasHit && !st_r.extraChk
		&& !restart |=> st_r.state == efa_pkg::IN_SYNC && fasInSync)
		else $error("sync not declared");
	a_extra_chk: assert property (st_r.state == efa_pkg::CHK_FAS && frameEnd && fasHit && st_r.extraChk
		&& !restart |=> st_r.state == efa_pkg::EXTRA_NFAS && !fasInSync)
		else $error("extra check skipped");
	a_extra_fas: assert property (st_r.state == efa_pkg::EXTRA_NFAS && frameEnd && nfasOk && !restart
		|=> st_r.state == efa_pkg::EXTRA_FAS)
		else $error("extra non-alignment frame not accepted");
	a_extra_sync: assert property (st_r.state == efa_pkg::EXTRA_FAS && frameEnd && fasHit && !restart
		|=> st_r.state == efa_pkg::IN_SYNC && fasInSync)
		else $error("sync not declared after extra frames");
	a_sync_held: assert property (st_r.state == efa_pkg::IN_SYNC && !restart
		|=> st_r.state == efa_pkg::IN_SYNC && fasInSync)
		else $error("sync dropped without restart");

	// Hold-off under the second algorithm ignores the pattern for one frame
	a_hold_off: assert property (st_r.state == efa_pkg::CHK_NFAS && frameEnd && !nfasOk && st_r.algSel
		&& !restart |=> st_r.state == efa_pkg::HOLD_OFF)
		else $error("no hold-off under algorithm two");
	a_hold_wait: assert property (st_r.state == efa_pkg::HOLD_OFF && !frameEnd && !restart
		|=> st_r.state == efa_pkg::HOLD_OFF)
		else $error("hold-off left before frame end");
	a_hold_end: assert property (st_r.state == efa_pkg::HOLD_OFF && frameEnd && !restart
		|=> st_r.state == efa_pkg::HUNT)
		else $error("hold-off not back to hunt");

	// Frame position: restart on the pattern, wrap after a whole frame
	a_frame_len: assert property (cntClear |=> frmCnt == 0)
		else $error("frame position not restarted");
	a_frame_wrap: assert property (frameEnd |=> frmCnt == 0)
		else $error("frame position not wrapped");

endmodule : efa_search

// >>> dv/efa_line_model.sv
// Line-side partner: sends whole E1 frames to the search block.
// Assumes one bit per strobe, bit 1 of each slot first, on ref_clk.
`timescale 1ns/100ps
`include "efa_params.svh"

module efa_line_model (
	input wire logic ref_clk,
	output logic rxBit,
	output logic rxBitEn
);
	// Quiet line at start
	initial begin
		rxBit = 1'b0;
		rxBitEn = 1'b0;
	end

	// One frame; fas picks slot 0 content, gap idles between bits
	task automatic sendFrame(input logic fas, input logic bit2, input int gap);
		logic [`EFA_FRAME_BITS-1:0] f; // Frame bits, index 0 sent first
		logic [6:0] pat;               // Alignment pattern
		pat = `EFA_FAS_PATTERN;
		f = '1; // Payload of ones never mimics the pattern
		if (fas) begin
			for (int i = 0; i < 7; i++) f[1+i] = pat[6-i];
		end else begin
			f[1] = bit2;
		end
		for (int i = 0; i < `EFA_FRAME_BITS; i++) begin
			@(posedge ref_clk);
			rxBit <= f[i];
			rxBitEn <= 1'b1;
			repeat (gap) begin
				@(posedge ref_clk);
				rxBitEn <= 1'b0;
				rxBit <= ~f[i]; // Stale bit is not held
			end
		end
		@(posedge ref_clk);
		rxBitEn <= 1'b0;
		rxBit <= ~rxBit; // Released line shows the inverse
	endtask : sendFrame
endmodule : efa_line_model

// >>> dv/e1_fas_alignment_search_tb_top.sv
// Self-checking bench of the E1 alignment search block.
// Assumes one AHB-Lite slave whose hreadyout is the bus ready, and the line partner model.
`timescale 1ns/100ps
`include "efa_params.svh"

module e1_fas_alignment_search_tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hrdata;
	logic [31:0] q; // Last read word
	logic rxBit, rxBitEn, hreadyout, hresp, irq, fasInSync;
	int errTotal = 0;
	int checkCount = 0;

	always #25 ref_clk = ~ref_clk; // 20 MHz

	efa_line_model efa_line_model_i (.ref_clk(ref_clk), .rxBit(rxBit), .rxBitEn(rxBitEn));
	efa_search efa_search_i (.ref_clk(ref_clk), .rst(rst), .rxBit(rxBit), .rxBitEn(rxBitEn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .fasInSync(fasInSync));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic finishTest();
		$display("checks %0d mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finishTest

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Waits for ready sampled high, bounded
	task automatic waitReady();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			errTotal++;
			$display("MISMATCH hreadyout expected 1 seen timeout");
			finishTest();
		end
	endtask : waitReady

	// One single word transfer, address then data phase
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitReady();
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : xfer

	task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		chk(nm, exp, q);
	endtask : rdChk

	task automatic frame(input logic fas, input logic bit2);
		efa_line_model_i.sendFrame(fas, bit2, 0);
	endtask : frame

	// Restart search and set algorithm and extra check
	task automatic setup(input logic [31:0] selWord);
		xfer(`EFA_CTRL_OFS, 1'b1, 32'h1);
		xfer(`EFA_FRAMING_SELECT_OFS, 1'b1, selWord);
		rdChk("framing select", `EFA_FRAMING_SELECT_OFS, selWord);
	endtask : setup

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic testReset();
		rdChk("framing select rst", `EFA_FRAMING_SELECT_OFS, 32'h0);
		rdChk("mask rst", `EFA_MASK_OFS, 32'h0);
		xfer(8'h40, 1'b1, 32'hFFFFFFFF);
		rdChk("unmapped", 8'h40, 32'h0);
		chk("sync rst", 32'h0, {31'h0, fasInSync});
		$display("testReset done");
	endtask : testReset

	task automatic testAlg1Sync();
		setup(32'h0);
		xfer(`EFA_MASK_OFS, 1'b1, 32'h3);
		frame(1'b1, 1'b0);
		rdChk("state nfas", `EFA_STATE_OFS, 32'h10);
		frame(1'b0, 1'b1);
		rdChk("state fas", `EFA_STATE_OFS, 32'h20);
		efa_line_model_i.sendFrame(1'b1, 1'b0, 1);
		repeat (2) @(posedge ref_clk);
		chk("sync", 32'h1, {31'h0, fasInSync});
		chk("irq set", 32'h1, {31'h0, irq});
		rdChk("status", `EFA_STATUS_OFS, 32'h1);
		rdChk("status clr", `EFA_STATUS_OFS, 32'h0);
		chk("irq clr", 32'h0, {31'h0, irq});
		rdChk("state sync", `EFA_STATE_OFS, 32'h61);
		$display("testAlg1Sync done");
	endtask : testAlg1Sync

	task automatic testAlg1Fail();
		setup(32'h0);
		xfer(`EFA_MASK_OFS, 1'b1, 32'h0);
		frame(1'b1, 1'b0);
		frame(1'b0, 1'b0);
		rdChk("state hunt", `EFA_STATE_OFS, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		rdChk("status fail", `EFA_STATUS_OFS, 32'h2);
		frame(1'b1, 1'b0);
		frame(1'b0, 1'b1);
		frame(1'b0, 1'b1);
		rdChk("third frame", `EFA_STATE_OFS, 32'h0);
		$display("testAlg1Fail done");
	endtask : testAlg1Fail

	task automatic testAlg2();
		setup(32'h1);
		frame(1'b1, 1'b0);
		frame(1'b0, 1'b0);
		rdChk("hold off", `EFA_STATE_OFS, 32'h50);
		frame(1'b1, 1'b0); // Pattern inside the hold-off frame is ignored
		rdChk("hold end", `EFA_STATE_OFS, 32'h0);
		frame(1'b1, 1'b0);
		frame(1'b0, 1'b1);
		rdChk("alg2 fas", `EFA_STATE_OFS, 32'h20);
		frame(1'b1, 1'b0);
		rdChk("alg2 sync", `EFA_STATE_OFS, 32'h61);
		$display("testAlg2 done");
	endtask : testAlg2

	task automatic testExtra();
		setup(32'h2);
		frame(1'b1, 1'b0);
		frame(1'b0, 1'b1);
		frame(1'b1, 1'b0);
		rdChk("extra nfas", `EFA_STATE_OFS, 32'h30);
		chk("no sync", 32'h0, {31'h0, fasInSync});
		frame(1'b0, 1'b1);
		rdChk("extra fas", `EFA_STATE_OFS, 32'h40);
		frame(1'b1, 1'b0);
		rdChk("extra sync", `EFA_STATE_OFS, 32'h61);
		$display("testExtra done");
	endtask : testExtra

	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		testReset();
		testAlg1Sync();
		testAlg1Fail();
		testAlg2();
		testExtra();
		finishTest();
	end
endmodule : e1_fas_alignment_search_tb_top
